// [shared/rm_pcs_pkg.sv]
// Shared constants and types for the basic-mode rate match channel.
package rm_pcs_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CAL_TIME_NS = 10000;
  localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYM_W = 9;
  localparam int SKIP_MAX_DEL = 4;
  localparam int SKIP_MAX_INS = 4;
  localparam int SKIP_CLUSTER_LIMIT = 5;
  localparam logic [8:0] EMPTY_FILL_SYM = 9'h1FE;
  localparam logic [8:0] SKIP_SYM_RESET = 9'h11C;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SKIP = 8'h04;
  localparam logic [7:0] ADDR_THRESH = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_STATE = 8'h14;
  localparam int CTRL_LOW_LAT = 0;
  localparam int CTRL_TX_IDLE = 1;
  localparam int CTRL_CODEC_EN = 2;
  localparam logic [2:0] CTRL_RESET = 3'h4;
  localparam int THR_HI_LSB = 0;
  localparam int THR_LO_LSB = 8;
  localparam logic [7:0] THR_HI_RESET = 8'h0C;
  localparam logic [7:0] THR_LO_RESET = 8'h04;
  localparam int EV_OVERFLOW = 0;
  localparam int EV_UNDERFLOW = 1;
  localparam int EV_DELETE = 2;
  localparam int EV_INSERT = 3;
  localparam int EV_CAL_DONE = 4;
  localparam int EV_W = 5;
  localparam int ST_CAL_BUSY = 8;
  localparam int ST_CAL_DONE = 9;
  localparam int ST_SIG_DET = 10;
  typedef enum logic [1:0] {RD_NONE, RD_POP, RD_INSERT, RD_EMPTY} rd_kind_t;
  typedef enum logic [1:0] {CAL_OFF, CAL_RUN, CAL_DONE} cal_state_t;
endpackage : rm_pcs_pkg

// [rtl/rm_sym_mem.sv]
// Small dual-port symbol store with registered read data.
`timescale 1ns/1ns
`default_nettype none
module rm_sym_mem #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : rm_sym_mem
`default_nettype wire

// [rtl/rm_cal_seq.sv]
// Calibration sequencer that restarts whenever its power-down is released.
`timescale 1ns/1ns
`default_nettype none
module rm_cal_seq
  import rm_pcs_pkg::*;
#(
  parameter int CYCLES = CAL_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic power_down,
  output logic cal_busy,
  output logic cal_done,
  output logic cal_done_pulse
);
  typedef struct packed {
    cal_state_t st;
    logic [31:0] cnt;
    logic busy;
    logic done;
    logic pulse;
  } cal_reg_t;

  cal_reg_t r_q, r_d;

  always_comb begin
    r_d = r_q;
    r_d.pulse = 1'b0;
    case (r_q.st)
      CAL_OFF: begin
        if (!power_down) begin
          r_d.st = CAL_RUN; // RULE_08
          r_d.cnt = '0;
        end
      end
      CAL_RUN: begin
        if (r_q.cnt == 32'(CYCLES - 1)) begin
          r_d.st = CAL_DONE;
          r_d.pulse = 1'b1;
        end else begin
          r_d.cnt = r_q.cnt + 32'h0000_0001;
        end
      end
      CAL_DONE: begin
      end
      default: begin
        r_d.st = CAL_OFF;
      end
    endcase
    if (power_down) begin
      r_d.st = CAL_OFF;
      r_d.pulse = 1'b0;
    end
    r_d.busy = (r_d.st == CAL_RUN);
    r_d.done = (r_d.st == CAL_DONE);
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      r_q <= '{st: CAL_RUN, cnt: 32'h0000_0000, busy: 1'b1, done: 1'b0, pulse: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  assign cal_busy = r_q.busy;
  assign cal_done = r_q.done;
  assign cal_done_pulse = r_q.pulse;
endmodule : rm_cal_seq
`default_nettype wire

// [rtl/basic_rate_match_pcs.sv]
// Basic-mode receive rate match FIFO with bypass, transmit idle and calibration control.
// How it works
// RULE_01: Delete at most four skips per cluster, always leaving at least one skip.
// RULE_02: Insert at most four skips per cluster, keeping the cluster below five skips.
// RULE_03: Drop the byte arriving at full; flag overflow with the next byte written.
// RULE_04: On empty emit K30.7 (9'h1FE) and flag underflow with that character.
// RULE_05: Low-latency option routes received symbols around the rate match path.
// RULE_06: Transmit electrical idle releases the differential driver, leaving common mode.
// RULE_07: Software enables signal detect only when 8B/10B coding is active.
// RULE_08: Calibration restarts each time its power-down input is released.
// RULE_09: Calibration clock from the fabric must not exceed 125 MHz.
// RULE_10: All channels share one calibration clock and one power-down signal.
// RULE_11: Overflow and underflow flags pulse for exactly one read cycle per event.
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module basic_rate_match_pcs
  import rm_pcs_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW = 4,
  parameter int CAL_LEN = CAL_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic [SYM_W-1:0] rx_in_sym,
  input wire logic rx_in_valid,
  input wire logic rx_out_req,
  output logic [SYM_W-1:0] rx_out_sym,
  output logic rx_out_valid,
  output logic rx_overflow,
  output logic rx_underflow,
  input wire logic rx_sig_det_pin,
  output logic rx_signal_detect,
  input wire logic tx_bit,
  output logic tx_p_out,
  output logic tx_n_out,
  output logic tx_p_oe,
  output logic tx_n_oe,
  input wire logic cal_power_down_pin,
  output logic cal_busy,
  output logic cal_done
);
  localparam int CW = AW + 1;
  localparam int MW = SYM_W + 1;

  typedef struct packed {
    logic [2:0] ctrl;
    logic [8:0] skip_sym;
    logic [7:0] thr_hi;
    logic [7:0] thr_lo;
    logic [EV_W-1:0] ev_status;
    logic [EV_W-1:0] ev_mask;
    logic [31:0] rdata;
    logic irq;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] count;
    logic ovf_pend;
    logic [2:0] wr_cluster;
    logic [2:0] wr_deleted;
    logic [2:0] rd_cluster;
    logic [2:0] rd_inserted;
    rd_kind_t rd_kind;
    logic [8:0] out_sym;
    logic out_valid;
    logic ovf_out;
    logic unf_out;
    logic sd_meta;
    logic sd_sync;
    logic pd_meta;
    logic pd_sync;
    logic sig_det;
    logic tx_p;
    logic tx_n;
    logic tx_oe;
  } state_t;

  state_t s_q, s_d;
  logic mem_we;
  logic [MW-1:0] mem_wdata;
  logic [MW-1:0] mem_rdata;
  logic cal_busy_w;
  logic cal_done_w;
  logic cal_pulse_w;

  function automatic logic [31:0] read_mux(input state_t s, input logic [7:0] a, input logic cb, input logic cd);
    logic [31:0] v;
    v = '0;
    case (a)
      ADDR_CTRL: v[2:0] = s.ctrl;
      ADDR_SKIP: v[8:0] = s.skip_sym;
      ADDR_THRESH: begin
        v[THR_HI_LSB +: 8] = s.thr_hi;
        v[THR_LO_LSB +: 8] = s.thr_lo;
      end
      ADDR_IRQ_STATUS: v[EV_W-1:0] = s.ev_status;
      ADDR_IRQ_MASK: v[EV_W-1:0] = s.ev_mask;
      ADDR_STATE: begin
        v[CW-1:0] = s.count;
        v[ST_CAL_BUSY] = cb;
        v[ST_CAL_DONE] = cd;
        v[ST_SIG_DET] = s.sig_det;
      end
      default: v = '0;
    endcase
    return v;
  endfunction : read_mux

  rm_sym_mem #(
    .WIDTH(MW),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .clock(clock),
    .wr_en(mem_we),
    .wr_addr(s_q.wptr),
    .wr_data(mem_wdata),
    .rd_addr(s_q.rptr),
    .rd_data(mem_rdata)
  );

  rm_cal_seq #(
    .CYCLES(CAL_LEN)
  ) u_cal (
    .clock(clock),
    .rst_b(rst_b),
    .power_down(s_q.pd_sync),
    .cal_busy(cal_busy_w),
    .cal_done(cal_done_w),
    .cal_done_pulse(cal_pulse_w)
  );

  always_comb begin
    logic [EV_W-1:0] ev;
    logic low_lat;
    logic is_skip;
    logic del;
    logic drop;
    logic pop;
    logic ins;
    logic last_skip;
    logic [2:0] cl;
    logic [2:0] ci;
    s_d = s_q;
    ev = '0;
    low_lat = s_q.ctrl[CTRL_LOW_LAT];
    del = 1'b0;
    drop = 1'b0;
    pop = 1'b0;
    ins = 1'b0;
    is_skip = 1'b0;
    last_skip = 1'b0;
    cl = 3'h0;
    ci = 3'h0;
    mem_we = 1'b0;
    mem_wdata = {s_q.ovf_pend, rx_in_sym};

    // Pin inputs pass two flops; only the second is looked at.
    s_d.sd_meta = rx_sig_det_pin;
    s_d.sd_sync = s_q.sd_meta;
    s_d.pd_meta = cal_power_down_pin;
    s_d.pd_sync = s_q.pd_meta;
    s_d.sig_det = s_q.sd_sync & s_q.ctrl[CTRL_CODEC_EN]; // RULE_07

    s_d.tx_oe = ~s_q.ctrl[CTRL_TX_IDLE]; // RULE_06
    s_d.tx_p = s_q.ctrl[CTRL_TX_IDLE] ? 1'b0 : tx_bit;
    s_d.tx_n = s_q.ctrl[CTRL_TX_IDLE] ? 1'b0 : ~tx_bit;

    // Write side: skip deletion and full handling.
    is_skip = (rx_in_sym == s_q.skip_sym);
    if (rx_in_valid && !low_lat) begin
      if (is_skip) begin
        if ((s_q.count >= CW'(s_q.thr_hi)) && (s_q.wr_cluster != 3'h0) &&
            (s_q.wr_deleted < 3'(SKIP_MAX_DEL))) begin
          del = 1'b1; // RULE_01
          s_d.wr_deleted = s_q.wr_deleted + 3'h1;
        end else if (s_q.wr_cluster != 3'h7) begin
          s_d.wr_cluster = s_q.wr_cluster + 3'h1;
        end
      end else begin
        s_d.wr_cluster = 3'h0;
        s_d.wr_deleted = 3'h0;
      end
      if (!del) begin
        if (s_q.count == CW'(DEPTH)) begin
          drop = 1'b1; // RULE_03
          s_d.ovf_pend = 1'b1;
        end else begin
          mem_we = 1'b1;
          s_d.ovf_pend = 1'b0;
          s_d.wptr = s_q.wptr + AW'(1);
        end
      end
    end

    // Output stage: the symbol read last cycle leaves now.
    s_d.out_valid = (s_q.rd_kind != RD_NONE);
    s_d.ovf_out = 1'b0;
    s_d.unf_out = 1'b0;
    cl = s_q.rd_cluster;
    ci = s_q.rd_inserted;
    last_skip = (s_q.rd_cluster != 3'h0);
    case (s_q.rd_kind)
      RD_POP: begin
        s_d.out_sym = mem_rdata[SYM_W-1:0];
        s_d.ovf_out = mem_rdata[SYM_W]; // RULE_03 RULE_11
        last_skip = (mem_rdata[SYM_W-1:0] == s_q.skip_sym);
        if (last_skip) begin
          cl = (s_q.rd_cluster == 3'h7) ? 3'h7 : s_q.rd_cluster + 3'h1;
        end else begin
          cl = 3'h0;
          ci = 3'h0;
        end
      end
      RD_INSERT: begin
        s_d.out_sym = s_q.skip_sym;
      end
      RD_EMPTY: begin
        s_d.out_sym = EMPTY_FILL_SYM; // RULE_04
        s_d.unf_out = 1'b1; // RULE_11
        // A fill symbol ends the cluster, so no skip may be repeated right after it.
        last_skip = 1'b0;
        cl = 3'h0;
        ci = 3'h0;
      end
      default: begin
        if (low_lat) begin
          s_d.out_sym = rx_in_sym; // RULE_05
          s_d.out_valid = rx_in_valid;
        end
      end
    endcase
    s_d.rd_cluster = cl;
    s_d.rd_inserted = ci;

    // Read side: pop, insert a skip, or fill an empty slot.
    s_d.rd_kind = RD_NONE;
    if (rx_out_req && !low_lat) begin
      if (last_skip && (s_q.count <= CW'(s_q.thr_lo)) && (ci < 3'(SKIP_MAX_INS)) &&
          (({1'b0, cl} + 4'h1) < 4'(SKIP_CLUSTER_LIMIT))) begin
        ins = 1'b1; // RULE_02
        s_d.rd_kind = RD_INSERT;
        s_d.rd_inserted = ci + 3'h1;
        s_d.rd_cluster = cl + 3'h1;
      end else if (s_q.count != '0) begin
        pop = 1'b1;
        s_d.rd_kind = RD_POP;
        s_d.rptr = s_q.rptr + AW'(1);
      end else begin
        s_d.rd_kind = RD_EMPTY; // RULE_04
      end
    end
    s_d.count = s_q.count + CW'(mem_we) - CW'(pop);
    if (low_lat) begin
      s_d.wptr = '0;
      s_d.rptr = '0;
      s_d.count = '0;
      s_d.ovf_pend = 1'b0;
    end

    ev[EV_OVERFLOW] = drop;
    ev[EV_UNDERFLOW] = (s_d.rd_kind == RD_EMPTY);
    ev[EV_DELETE] = del;
    ev[EV_INSERT] = ins;
    ev[EV_CAL_DONE] = cal_pulse_w;

    // Register port; a status bit set by hardware beats a write-one clear.
    s_d.rdata = reg_rd ? read_mux(s_q, reg_addr, cal_busy_w, cal_done_w) : 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL: s_d.ctrl = reg_wdata[2:0];
        ADDR_SKIP: s_d.skip_sym = reg_wdata[8:0];
        ADDR_THRESH: begin
          s_d.thr_hi = reg_wdata[THR_HI_LSB +: 8];
          s_d.thr_lo = reg_wdata[THR_LO_LSB +: 8];
        end
        ADDR_IRQ_STATUS: s_d.ev_status = s_q.ev_status & ~reg_wdata[EV_W-1:0];
        ADDR_IRQ_MASK: s_d.ev_mask = reg_wdata[EV_W-1:0];
        default: begin
        end
      endcase
    end
    s_d.ev_status = s_d.ev_status | ev;
    s_d.irq = |(s_d.ev_status & s_d.ev_mask);
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RESET;
      s_q.skip_sym <= SKIP_SYM_RESET;
      s_q.thr_hi <= THR_HI_RESET;
      s_q.thr_lo <= THR_LO_RESET;
      s_q.rd_kind <= RD_NONE;
      s_q.pd_meta <= 1'b1;
      s_q.pd_sync <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign irq = s_q.irq;
  assign rx_out_sym = s_q.out_sym;
  assign rx_out_valid = s_q.out_valid;
  assign rx_overflow = s_q.ovf_out;
  assign rx_underflow = s_q.unf_out;
  assign rx_signal_detect = s_q.sig_det;
  assign tx_p_out = s_q.tx_p;
  assign tx_n_out = s_q.tx_n;
  assign tx_p_oe = s_q.tx_oe;
  assign tx_n_oe = s_q.tx_oe;
  // Calibration state leaves through its own flops inside the sequencer.
  assign cal_busy = cal_busy_w;
  assign cal_done = cal_done_w;
endmodule : basic_rate_match_pcs
`default_nettype wire

// [tb/rm_pcs_asserts.sv]
// Port checker for the basic-mode rate match channel.
`timescale 1ns/1ns
`default_nettype none
module rm_pcs_asserts
  import rm_pcs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [SYM_W-1:0] rx_out_sym,
  input wire logic rx_out_valid,
  input wire logic rx_overflow,
  input wire logic rx_underflow,
  input wire logic tx_p_out,
  input wire logic tx_n_out,
  input wire logic tx_p_oe,
  input wire logic tx_n_oe,
  input wire logic cal_power_down_pin,
  input wire logic cal_busy,
  input wire logic cal_done
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_pd_held;
    cal_power_down_pin [*6];
  endsequence
  sequence s_pd_release;
    s_pd_held ##1 !cal_power_down_pin;
  endsequence
  property p_unf_fill;
    rx_underflow |-> rx_out_valid && rx_out_sym == EMPTY_FILL_SYM;
  endproperty
  property p_ovf_data;
    rx_overflow |-> rx_out_valid && rx_out_sym != EMPTY_FILL_SYM;
  endproperty
  property p_flag_excl;
    !(rx_overflow && rx_underflow);
  endproperty
  property p_rdata;
    reg_rdata != 32'h0000_0000 |-> $past(reg_rd);
  endproperty
  property p_idle_low;
    !tx_p_oe |-> !tx_p_out && !tx_n_out;
  endproperty
  property p_oe_pair;
    tx_p_oe == tx_n_oe;
  endproperty
  property p_diff;
    tx_p_oe |-> tx_p_out != tx_n_out;
  endproperty
  property p_cal_off;
    s_pd_held |-> !cal_busy && !cal_done;
  endproperty
  property p_cal_restart;
    s_pd_release |-> ##[1:6] cal_busy;
  endproperty
  property p_cal_excl;
    !(cal_busy && cal_done);
  endproperty
  a_unf_fill: assert property (p_unf_fill) else $error("underflow without fill");
  a_ovf_data: assert property (p_ovf_data) else $error("overflow off data");
  a_flag_excl: assert property (p_flag_excl) else $error("both flags high");
  a_rdata: assert property (p_rdata) else $error("read data without strobe");
  a_idle_low: assert property (p_idle_low) else $error("idle output driven");
  a_oe_pair: assert property (p_oe_pair) else $error("enables differ");
  a_diff: assert property (p_diff) else $error("outputs not differential");
  a_cal_off: assert property (p_cal_off) else $error("calibration runs in power down");
  a_cal_restart: assert property (p_cal_restart) else $error("calibration not restarted");
  a_cal_excl: assert property (p_cal_excl) else $error("busy and done together");
endmodule : rm_pcs_asserts
bind basic_rate_match_pcs rm_pcs_asserts u_chk (.clock(clock), .rst_b(rst_b), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_out_sym(rx_out_sym), .rx_out_valid(rx_out_valid), .rx_overflow(rx_overflow),
  .rx_underflow(rx_underflow), .tx_p_out(tx_p_out), .tx_n_out(tx_n_out), .tx_p_oe(tx_p_oe), .tx_n_oe(tx_n_oe),
  .cal_power_down_pin(cal_power_down_pin), .cal_busy(cal_busy), .cal_done(cal_done));
`default_nettype wire

// [tb/rm_fabric_reader.sv]
// Fabric reader that requests a counted run of symbols and records them.
`timescale 1ns/1ns
`default_nettype none
module rm_fabric_reader
  import rm_pcs_pkg::*;
(
  input wire logic clock,
  input wire logic go,
  input wire logic [7:0] count,
  input wire logic stall_en,
  output logic rx_out_req,
  input wire logic [SYM_W-1:0] rx_out_sym,
  input wire logic rx_out_valid,
  input wire logic rx_overflow,
  input wire logic rx_underflow
);
  logic [10:0] got[$];
  logic [7:0] left = 8'h00;
  integer sd = 32'h562f_0568;
  initial rx_out_req = 1'b0;
  // Stalls only stretch the run, so the order of symbols must not change.
  always @(posedge clock) begin
    if (rx_out_valid) begin
      got.push_back({rx_overflow, rx_underflow, rx_out_sym});
    end
    if (go) begin
      left <= count;
      rx_out_req <= 1'b0;
    end else if (left != 8'h00 && !(stall_en && $random(sd) & 1)) begin
      left <= left - 8'h01;
      rx_out_req <= 1'b1;
    end else begin
      rx_out_req <= 1'b0;
    end
  end
endmodule : rm_fabric_reader
`default_nettype wire

// [tb/basic_rate_match_pcs_tb.sv]
// Self-checking bench for the basic-mode rate match channel.
`timescale 1ns/1ns
`default_nettype none
module basic_rate_match_pcs_tb;
  import rm_pcs_pkg::*;
  logic clock, rst_b, reg_wr, reg_rd, irq, rx_in_valid, rx_out_req, rx_out_valid, rx_overflow, rx_underflow;
  logic rx_sig_det_pin, rx_signal_detect, tx_bit, tx_p_out, tx_n_out, tx_p_oe, tx_n_oe;
  logic cal_power_down_pin, cal_busy, cal_done, go, stall_en;
  logic [7:0] reg_addr, count;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [8:0] rx_in_sym, rx_out_sym, x;
  logic [8:0] dd[17];
  logic [10:0] exp[$];
  logic [7:0] ra[5] = '{ADDR_CTRL, ADDR_SKIP, ADDR_THRESH, ADDR_IRQ_MASK, 8'h20};
  logic [31:0] rv[5] = '{32'h0000_0004, 32'h0000_011c, 32'h0000_040c, 32'h0000_0000, 32'h0000_0000};
  int failures = 0;
  int total_checks = 0;
  integer seed = 32'h562f_0568;
  basic_rate_match_pcs #(.CAL_LEN(8)) dut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .rx_in_sym(rx_in_sym), .rx_in_valid(rx_in_valid), .rx_out_req(rx_out_req), .rx_out_sym(rx_out_sym),
    .rx_out_valid(rx_out_valid), .rx_overflow(rx_overflow), .rx_underflow(rx_underflow),
    .rx_sig_det_pin(rx_sig_det_pin), .rx_signal_detect(rx_signal_detect), .tx_bit(tx_bit),
    .tx_p_out(tx_p_out), .tx_n_out(tx_n_out), .tx_p_oe(tx_p_oe), .tx_n_oe(tx_n_oe),
    .cal_power_down_pin(cal_power_down_pin), .cal_busy(cal_busy), .cal_done(cal_done));
  rm_fabric_reader fab (.clock(clock), .go(go), .count(count), .stall_en(stall_en), .rx_out_req(rx_out_req),
    .rx_out_sym(rx_out_sym), .rx_out_valid(rx_out_valid), .rx_overflow(rx_overflow), .rx_underflow(rx_underflow));
  // One slow clock serves calibration for every channel as well.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic finish_test();
    if (failures == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic push(input logic [8:0] s);
    @(posedge clock);
    rx_in_sym <= s;
    rx_in_valid <= 1'b1;
  endtask : push
  task automatic idle();
    @(posedge clock);
    rx_in_valid <= 1'b0;
  endtask : idle
  task automatic drain(input int n, input logic st);
    int k;
    @(posedge clock);
    go <= 1'b1;
    count <= 8'(n);
    stall_en <= st;
    @(posedge clock);
    go <= 1'b0;
    k = 0;
    while (fab.got.size() < n && k < 300) begin
      @(posedge clock);
      k++;
    end
    repeat (3) @(posedge clock);
    chk("stream length", 32'(exp.size()), 32'(fab.got.size()));
    foreach (exp[i]) chk("stream symbol", {21'h0, exp[i]}, {21'h0, fab.got[i]});
    exp.delete();
    fab.got.delete();
  endtask : drain
  initial begin
    #200000;
    failures++;
    finish_test();
  end
  initial begin
    {rst_b, reg_wr, reg_rd, rx_in_valid, rx_sig_det_pin, tx_bit, cal_power_down_pin, go, stall_en} = 9'h000;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    rx_in_sym = 9'h000;
    count = 8'h00;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i], v);
      chk("register reset", rv[i], v);
    end
    wr(ADDR_IRQ_MASK, 32'h0000_000f);
    exp.push_back({2'b01, EMPTY_FILL_SYM});
    drain(1, 1'b0);
    rd(ADDR_IRQ_STATUS, v);
    chk("underflow status", 32'h0000_0002, v & 32'h0000_000f);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(ADDR_IRQ_STATUS, 32'h0000_001f);
    repeat (2) @(posedge clock);
    chk("irq cleared", 32'h0, {31'h0, irq});
    foreach (dd[i]) begin
      dd[i] = {1'b0, 8'($random(seed))};
      push(dd[i]);
    end
    idle();
    exp.push_back({2'b00, dd[0]});
    drain(1, 1'b0);
    x = {1'b0, 8'($random(seed))};
    push(x);
    idle();
    for (int i = 1; i < 16; i++) exp.push_back({2'b00, dd[i]});
    exp.push_back({2'b10, x});
    drain(16, 1'b1);
    rd(ADDR_IRQ_STATUS, v);
    chk("overflow status", 32'h0000_0001, v & 32'h0000_000f);
    wr(ADDR_IRQ_STATUS, 32'h0000_001f);
    wr(ADDR_THRESH, 32'h0000_000c);
    for (int i = 0; i < 19; i++) begin
      x = (i >= 12 && i < 18) ? SKIP_SYM_RESET : {1'b0, 8'($random(seed))};
      push(x);
      if (i < 14 || i == 18) exp.push_back({2'b00, x});
    end
    idle();
    drain(15, 1'b1);
    wr(ADDR_THRESH, 32'h0000_040c);
    x = {1'b0, 8'($random(seed))};
    push(x);
    push(SKIP_SYM_RESET);
    idle();
    exp.push_back({2'b00, x});
    repeat (4) exp.push_back({2'b00, SKIP_SYM_RESET});
    repeat (2) exp.push_back({2'b01, EMPTY_FILL_SYM});
    drain(7, 1'b0);
    rd(ADDR_IRQ_STATUS, v);
    chk("skip status", 32'h0000_000e, v & 32'h0000_000f);
    wr(ADDR_CTRL, 32'h0000_0005);
    for (int i = 0; i < 8; i++) begin
      x = (i == 3) ? SKIP_SYM_RESET : 9'($random(seed));
      push(x);
      @(posedge clock);
      #1 chk("bypass symbol", {22'h0, 1'b1, x}, {22'h0, rx_out_valid, rx_out_sym});
    end
    idle();
    wr(ADDR_CTRL, 32'h0000_0006);
    fab.got.delete();
    repeat (2) @(posedge clock);
    #1 chk("idle drive", 32'h0, {28'h0, tx_p_oe, tx_n_oe, tx_p_out, tx_n_out});
    wr(ADDR_CTRL, 32'h0000_0004);
    tx_bit <= 1'b1;
    rx_sig_det_pin <= 1'b1;
    repeat (4) @(posedge clock);
    #1 chk("active drive", 32'he, {28'h0, tx_p_oe, tx_n_oe, tx_p_out, tx_n_out});
    chk("signal detect", 32'h1, {31'h0, rx_signal_detect});
    rd(ADDR_STATE, v);
    chk("state word", 32'h0000_0600, v);
    wr(ADDR_CTRL, 32'h0000_0000);
    repeat (2) @(posedge clock);
    #1 chk("detect gated", 32'h0, {31'h0, rx_signal_detect});
    @(posedge clock);
    cal_power_down_pin <= 1'b1;
    repeat (10) @(posedge clock);
    #1 chk("cal off", 32'h0, {30'h0, cal_busy, cal_done});
    @(posedge clock);
    cal_power_down_pin <= 1'b0;
    repeat (5) @(posedge clock);
    #1 chk("cal restart", 32'h2, {30'h0, cal_busy, cal_done});
    repeat (12) @(posedge clock);
    #1 chk("cal finish", 32'h1, {30'h0, cal_busy, cal_done});
    finish_test();
  end
endmodule : basic_rate_match_pcs_tb
`default_nettype wire
